// ==== rtl/mpcd_pkg.sv ====
/*
 Shared constants and carriers of the motion parameter command decoder:
 APB offsets, command codes, field positions, ranges, timing counts.
 Assumes a 100 MHz pclk and 8-bit APB byte addresses.
*/
package mpcd_pkg;
	// apb byte offsets
	localparam logic [7:0] OFS_COMMAND    = 8'h00;
	localparam logic [7:0] OFS_WDATA_LOW  = 8'h04;
	localparam logic [7:0] OFS_WDATA_HIGH = 8'h08;
	localparam logic [7:0] OFS_RDATA_LOW  = 8'h0c;
	localparam logic [7:0] OFS_RDATA_HIGH = 8'h10;
	localparam logic [7:0] OFS_STATUS     = 8'h14;
	// command register fields
	localparam int CMD_CODE_LSB = 0;
	localparam int CMD_AXIS_LSB = 8;
	// status register fields
	localparam int STAT_RANGE_BIT = 0;
	localparam int STAT_BUSY_BIT  = 1;
	// reset values
	localparam logic [15:0] RST_WORD16 = 16'h0000;
	localparam logic [31:0] RST_WORD32 = 32'h0000_0000;
	// data-write codes
	localparam logic [7:0] C_UP_JERK    = 8'h00;
	localparam logic [7:0] C_DN_JERK    = 8'h01;
	localparam logic [7:0] C_UP_RATE    = 8'h02;
	localparam logic [7:0] C_DN_RATE    = 8'h03;
	localparam logic [7:0] C_START_SPD  = 8'h04;
	localparam logic [7:0] C_TARGET_SPD = 8'h05;
	localparam logic [7:0] C_MOVE_LEN   = 8'h06;
	localparam logic [7:0] C_SLOWDOWN   = 8'h07;
	localparam logic [7:0] C_ARC        = 8'h08;
	localparam logic [7:0] C_CMD_POS    = 8'h09;
	localparam logic [7:0] C_FB_POS     = 8'h0a;
	localparam logic [7:0] C_UPPER      = 8'h0b;
	localparam logic [7:0] C_LOWER      = 8'h0c;
	localparam logic [7:0] C_GEN_FIRST  = 8'h10;
	localparam logic [7:0] C_GEN_LAST   = 8'h13;
	localparam logic [7:0] C_HOMING     = 8'h14;
	localparam logic [7:0] C_STEP       = 8'h15;
	localparam logic [7:0] C_TIMER      = 8'h16;
	localparam logic [7:0] C_BURST_SHP  = 8'h17;
	localparam logic [7:0] C_BURST_CNT  = 8'h18;
	localparam logic [7:0] C_WRAP       = 8'h19;
	localparam logic [7:0] C_MODE_FIRST = 8'h20;
	localparam logic [7:0] C_MODE_LAST  = 8'h2b;
	// data-read codes
	localparam logic [7:0] R_CMD_POS    = 8'h30;
	localparam logic [7:0] R_FB_POS     = 8'h31;
	localparam logic [7:0] R_SPEED      = 8'h32;
	localparam logic [7:0] R_RAMP       = 8'h33;
	localparam logic [7:0] R_GEN_FIRST  = 8'h34;
	localparam logic [7:0] R_GEN_LAST   = 8'h37;
	localparam logic [7:0] R_TIMER      = 8'h38;
	localparam logic [7:0] R_WRAP       = 8'h39;
	localparam logic [7:0] R_WCFG1      = 8'h3d;
	localparam logic [7:0] R_WCFG2      = 8'h3e;
	localparam logic [7:0] R_WCFG3      = 8'h3f;
	localparam logic [7:0] R_MODE0      = 8'h40;
	localparam logic [7:0] R_MODE1      = 8'h41;
	localparam logic [7:0] R_MODE2      = 8'h42;
	localparam logic [7:0] R_UP_RATE    = 8'h43;
	localparam logic [7:0] R_START_SPD  = 8'h44;
	localparam logic [7:0] R_TARGET_SPD = 8'h45;
	localparam logic [7:0] R_MOVE_LEN   = 8'h46;
	localparam logic [7:0] R_BURST_SHP  = 8'h47;
	localparam logic [7:0] R_GEN_INPUT  = 8'h48;
	localparam logic [7:0] R_MODE11     = 8'h49;
	// mode word slots read back by 40h..42h and 49h
	localparam int MODE_SLOT0  = 0;
	localparam int MODE_SLOT1  = 1;
	localparam int MODE_SLOT2  = 2;
	localparam int MODE_SLOT11 = 11;
	// permitted ranges
	localparam logic [31:0] MAX_JERK  = 32'h3fff_ffff;
	localparam logic [31:0] MAX_RATE  = 32'h1fff_ffff;
	localparam logic [31:0] MAX_SPEED = 32'h007a_1200;
	localparam logic [31:0] MAX_STEP  = 32'h000f_4240;
	localparam logic [31:0] MAX_SLOW  = 32'hffff_fffc;
	localparam logic [31:0] MAX_POS   = 32'h7fff_fffe;
	localparam logic [31:0] MAX_TIME  = 32'h7fff_ffff;
	localparam logic [31:0] MOST_NEG  = 32'h8000_0000;
	localparam logic [15:0] MIN_SPLIT = 16'h0002;
	localparam logic [15:0] MAX_WIDTH = 16'hfffe;
	// command access time
	localparam int CLK_PERIOD_NS = 10;
	localparam int CMD_ACCESS_NS = 125;
	localparam int CMD_BUSY_CYC  = (CMD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] BUSY_LOAD = 4'(CMD_BUSY_CYC);
	localparam logic [3:0] BUSY_IDLE = 4'h0;

	typedef struct packed {
		logic [31:0]       ramp_up_jerk;
		logic [31:0]       ramp_down_jerk;
		logic [31:0]       speed_ramp_up_rate;
		logic [31:0]       speed_ramp_down_rate;
		logic [31:0]       start_speed;
		logic [31:0]       target_speed;
		logic [31:0]       move_length_or_goal;
		logic [31:0]       manual_slowdown_point;
		logic [31:0]       arc_center;
		logic [31:0]       commanded_position_count;
		logic [31:0]       feedback_position_count;
		logic [31:0]       upper_soft_bound;
		logic [31:0]       lower_soft_bound;
		logic [3:0][31:0]  general_register;
		logic [31:0]       homing_speed;
		logic [31:0]       speed_step;
		logic [31:0]       timer_preset;
		logic [31:0]       burst_shape;
		logic [15:0]       burst_count;
		logic [31:0]       wrap_limit;
		logic [11:0][15:0] mode_word;
	} mpcd_params_s;

	typedef struct packed {
		logic [31:0] present_speed;
		logic [31:0] present_ramp_rate;
		logic [31:0] present_timer;
		logic [15:0] general_input_value;
		logic [15:0] write_cfg1;
		logic [15:0] write_cfg2;
		logic [15:0] write_cfg3;
	} mpcd_live_s;

	typedef struct packed {
		logic       valid;
		logic [1:0] axes;
		logic [7:0] code;
	} mpcd_cmd_s;
endpackage

// ==== rtl/mpcd_decoder.sv ====
/*
 Motion parameter command decoder: APB slave holding the command,
 write-data and read-data registers, the per-axis parameter store
 and the read-back multiplexer for two axes.
 Assumes live values arrive from logic on pclk, and that driving
 logic elsewhere consumes the parameters and the command strobe.
*/
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module mpcd_decoder (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire mpcd_pkg::mpcd_live_s     [1:0] axis_live,
	output mpcd_pkg::mpcd_params_s        [1:0] axis_params,
	output mpcd_pkg::mpcd_cmd_s           cmd_out
);
	import mpcd_pkg::*;

	logic [15:0]        wlow_reg;
	logic [15:0]        whigh_reg;
	logic [15:0]        rlow_reg;
	logic [15:0]        rhigh_reg;
	logic [31:0]        prdata_reg;
	logic [3:0]         busy_reg;
	logic               range_err_reg;
	mpcd_cmd_s          cmd_reg;
	mpcd_params_s [1:0] par_reg;
	logic               access;
	logic               done;
	logic               wr_en;
	logic               cmd_go;
	logic               addr_ok;
	logic               addr_ro;
	logic [7:0]         code;
	logic [1:0]         axes;
	logic [31:0]        wdata;
	logic               src_axis;
	logic [32:0]        rd_word;
	logic               busy;
	logic               rd_load;
	logic               err_set;

	// true when the code lies inside a contiguous group of codes
	function automatic logic in_span(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
		in_span = c >= lo && c <= hi;
	endfunction

	// true when the value lies outside the permitted range of the code
	function automatic logic range_bad(input logic [7:0] c, input logic [31:0] d);
		logic lo;
		logic hi;
		lo = d[15:0] < MIN_SPLIT;
		hi = d[31:16] == RST_WORD16;
		case (c)
			C_UP_JERK, C_DN_JERK:
				range_bad = d == RST_WORD32 || d > MAX_JERK;
			C_UP_RATE, C_DN_RATE:
				range_bad = d == RST_WORD32 || d > MAX_RATE;
			C_START_SPD, C_TARGET_SPD, C_HOMING:
				range_bad = d == RST_WORD32 || d > MAX_SPEED;
			C_STEP:
				range_bad = d == RST_WORD32 || d > MAX_STEP;
			C_SLOWDOWN:
				range_bad = d > MAX_SLOW;
			C_MOVE_LEN, C_ARC:
				range_bad = $signed(d) > $signed(MAX_POS) || $signed(d) < -$signed(MAX_POS);
			C_UPPER, C_LOWER:
				range_bad = d == MOST_NEG;
			C_TIMER:
				range_bad = d == RST_WORD32 || d > MAX_TIME;
			C_WRAP:
				range_bad = d == RST_WORD32 || d > MAX_POS;
			C_BURST_SHP:
				range_bad = lo || hi || d[31:16] > MAX_WIDTH;
			default:
				range_bad = 1'b0;
		endcase
	endfunction

	// read-back value of one axis, top bit flags a known read code
	function automatic logic [32:0] read_word(
		input mpcd_params_s p,
		input mpcd_live_s   l,
		input logic [7:0]   c
	);
		read_word = {1'b1, RST_WORD32};
		case (c)
			R_CMD_POS:
				read_word[31:0] = p.commanded_position_count;
			R_FB_POS:
				read_word[31:0] = p.feedback_position_count;
			R_SPEED:
				read_word[31:0] = l.present_speed;
			R_RAMP:
				read_word[31:0] = l.present_ramp_rate;
			R_TIMER:
				read_word[31:0] = l.present_timer;
			R_WRAP:
				read_word[31:0] = p.wrap_limit;
			R_WCFG1:
				read_word[15:0] = l.write_cfg1;
			R_WCFG2:
				read_word[15:0] = l.write_cfg2;
			R_WCFG3:
				read_word[15:0] = l.write_cfg3;
			R_MODE0:
				read_word[15:0] = p.mode_word[MODE_SLOT0];
			R_MODE1:
				read_word[15:0] = p.mode_word[MODE_SLOT1];
			R_MODE2:
				read_word[15:0] = p.mode_word[MODE_SLOT2];
			R_MODE11:
				read_word[15:0] = p.mode_word[MODE_SLOT11];
			R_UP_RATE:
				read_word[31:0] = p.speed_ramp_up_rate;
			R_START_SPD:
				read_word[31:0] = p.start_speed;
			R_TARGET_SPD:
				read_word[31:0] = p.target_speed;
			R_MOVE_LEN:
				read_word[31:0] = p.move_length_or_goal;
			R_BURST_SHP:
				read_word[31:0] = p.burst_shape;
			R_GEN_INPUT:
				read_word[15:0] = l.general_input_value;
			default:
				if (in_span(c, R_GEN_FIRST, R_GEN_LAST)) begin
					read_word[31:0] = p.general_register[c[1:0]];
				end else begin
					read_word = {1'b0, RST_WORD32};
				end
		endcase
	endfunction

	// apb handshake; writes wait out the command access time
	assign access  = psel & penable;
	assign pready  = ~(pwrite & busy);
	assign done    = access & pready;
	assign wr_en   = done & pwrite;
	assign cmd_go  = wr_en & (paddr == OFS_COMMAND);
	assign code    = pwdata[CMD_CODE_LSB +: 8];
	assign axes    = pwdata[CMD_AXIS_LSB +: 2];
	assign wdata   = {whigh_reg, wlow_reg};
	assign src_axis = ~axes[0];
	assign rd_word = read_word(par_reg[src_axis], axis_live[src_axis], code);

	// read results and the range flag only follow a command to a selected axis
	assign busy    = busy_reg != BUSY_IDLE;
	assign rd_load = cmd_go & (axes != 2'b00) & rd_word[32];
	assign err_set = cmd_go & (axes != 2'b00) & range_bad(code, wdata);

	// address decode; read-data words are read-only
	always_comb begin
		addr_ok = 1'b1;
		addr_ro = 1'b0;
		case (paddr)
			OFS_COMMAND, OFS_WDATA_LOW, OFS_WDATA_HIGH, OFS_STATUS:
				addr_ok = 1'b1;
			OFS_RDATA_LOW, OFS_RDATA_HIGH:
				addr_ro = 1'b1;
			default:
				addr_ok = 1'b0;
		endcase
	end

	assign pslverr     = access & (~addr_ok | (pwrite & addr_ro));
	assign prdata      = prdata_reg;
	assign axis_params = par_reg;
	assign cmd_out     = cmd_reg;

	// read data captured in the setup cycle so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= RST_WORD32;
		end else if (psel & ~penable & ~pwrite) begin
			case (paddr)
				OFS_COMMAND:
					prdata_reg <= {22'h0, cmd_reg.axes, cmd_reg.code};
				OFS_WDATA_LOW:
					prdata_reg <= {16'h0, wlow_reg};
				OFS_WDATA_HIGH:
					prdata_reg <= {16'h0, whigh_reg};
				OFS_RDATA_LOW:
					prdata_reg <= {16'h0, rlow_reg};
				OFS_RDATA_HIGH:
					prdata_reg <= {16'h0, rhigh_reg};
				OFS_STATUS:
					prdata_reg <= {30'h0, busy, range_err_reg};
				default:
					prdata_reg <= RST_WORD32;
			endcase
		end
	end

	// write-data words; a 2-byte parameter uses only the low word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wlow_reg  <= RST_WORD16;
			whigh_reg <= RST_WORD16;
		end else if (wr_en) begin
			if (paddr == OFS_WDATA_LOW) begin
				wlow_reg <= pwdata[15:0];
			end
			if (paddr == OFS_WDATA_HIGH) begin
				whigh_reg <= pwdata[15:0];
			end
		end
	end

	// command access window, loaded by each command write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= BUSY_IDLE;
		end else if (cmd_go) begin
			busy_reg <= BUSY_LOAD;
		end else if (busy) begin
			busy_reg <= busy_reg - 4'h1;
		end
	end

	// command strobe for the driving groups outside this block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg <= '0;
		end else if (cmd_go) begin
			cmd_reg <= '{valid: 1'b1, axes: axes, code: code};
		end else begin
			cmd_reg.valid <= 1'b0;
		end
	end

	// sticky range flag, write one to clear; a new error wins the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			range_err_reg <= 1'b0;
		end else if (err_set) begin
			range_err_reg <= 1'b1;
		end else if (wr_en && paddr == OFS_STATUS && pwdata[STAT_RANGE_BIT]) begin
			range_err_reg <= 1'b0;
		end
	end

	// read commands; lowest selected axis answers, 2-byte results zero-extend
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rlow_reg  <= RST_WORD16;
			rhigh_reg <= RST_WORD16;
		end else if (rd_load) begin
			rlow_reg  <= rd_word[15:0];
			rhigh_reg <= rd_word[31:16];
		end
	end

	// one command applied to an axis store; 2-byte codes take the low word only
	function automatic mpcd_params_s store_word(
		input mpcd_params_s p,
		input logic [7:0]   c,
		input logic [31:0]  w
	);
		mpcd_params_s s;
		s = p;
		case (c)
			C_UP_JERK: begin
				s.ramp_up_jerk = w;
			end
			C_DN_JERK: begin
				s.ramp_down_jerk = w;
			end
			C_UP_RATE: begin
				s.speed_ramp_up_rate = w;
			end
			C_DN_RATE: begin
				s.speed_ramp_down_rate = w;
			end
			C_START_SPD: begin
				s.start_speed = w;
			end
			C_TARGET_SPD: begin
				s.target_speed = w;
			end
			C_MOVE_LEN: begin
				s.move_length_or_goal = w;
			end
			C_ARC: begin
				s.arc_center = w;
			end
			C_SLOWDOWN: begin
				s.manual_slowdown_point = w;
			end
			C_CMD_POS: begin
				s.commanded_position_count = w;
			end
			C_FB_POS: begin
				s.feedback_position_count = w;
			end
			C_UPPER: begin
				s.upper_soft_bound = w;
			end
			C_LOWER: begin
				s.lower_soft_bound = w;
			end
			C_HOMING: begin
				s.homing_speed = w;
			end
			C_STEP: begin
				s.speed_step = w;
			end
			C_TIMER: begin
				s.timer_preset = w;
			end
			C_BURST_SHP: begin
				s.burst_shape = w;
			end
			C_BURST_CNT: begin
				s.burst_count = w[15:0];
			end
			C_WRAP: begin
				s.wrap_limit = w;
			end
			default: begin
				if (in_span(c, C_GEN_FIRST, C_GEN_LAST)) begin
					s.general_register[c[1:0]] = w;
				end else if (in_span(c, C_MODE_FIRST, C_MODE_LAST)) begin
					s.mode_word[c[3:0]] = w[15:0];
				end
				// other codes leave the store alone
			end
		endcase
		store_word = s;
	endfunction

	// parameter store in one process; both axes load together when both are selected
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			par_reg <= '0;
		end else if (cmd_go) begin
			for (int a = 0; a < 2; a++) begin
				if (axes[a]) begin
					par_reg[a] <= store_word(par_reg[a], code, wdata);
				end
			end
		end
	end
	// out-of-range values are stored as written and only flagged
endmodule

// ==== tb/mpcd_decoder_properties.sv ====
/*
 Checker: concurrent properties on the decoder's APB, parameter and command ports.
 Assumes one pclk domain and the register map of mpcd_pkg.
*/
`timescale 1ns/1ps
module mpcd_decoder_props
	import mpcd_pkg::*;
(
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [7:0]                   paddr,
	input wire logic [31:0]                  pwdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	input wire mpcd_pkg::mpcd_params_s [1:0] axis_params,
	input wire mpcd_pkg::mpcd_cmd_s          cmd_out
);
	logic        acc;
	logic        wr_cmd;
	logic [7:0]  code;
	logic [15:0] wl_reg;
	logic [15:0] wh_reg;

	// accepted transfers and the command byte
	assign acc    = psel && penable && pready;
	assign wr_cmd = acc && pwrite && paddr == OFS_COMMAND;
	assign code   = pwdata[7:0];

	// shadow of the data words, so a command knows what it must store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wl_reg <= 16'h0000;
			wh_reg <= 16'h0000;
		end else if (acc && pwrite && paddr == OFS_WDATA_LOW) begin
			wl_reg <= pwdata[15:0];
		end else if (acc && pwrite && paddr == OFS_WDATA_HIGH) begin
			wh_reg <= pwdata[15:0];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_jerk;
		wr_cmd && code == C_UP_JERK && pwdata[8] |=> axis_params[0].ramp_up_jerk == {wh_reg, wl_reg};
	endproperty
	a_jerk: assert property (p_jerk) else $error("jerk not stored");
	property p_pos;
		wr_cmd && code == C_CMD_POS && pwdata[9] |=> axis_params[1].commanded_position_count == {wh_reg, wl_reg};
	endproperty
	a_pos: assert property (p_pos) else $error("position preset not stored");
	property p_gen;
		wr_cmd && code >= C_GEN_FIRST && code <= C_GEN_LAST && pwdata[9]
		|=> axis_params[1].general_register[$past(pwdata[1:0])] == {wh_reg, wl_reg};
	endproperty
	a_gen: assert property (p_gen) else $error("general register not stored");
	property p_mode;
		wr_cmd && code >= C_MODE_FIRST && code <= C_MODE_LAST && pwdata[8]
		|=> axis_params[0].mode_word[$past(pwdata[3:0])] == wl_reg;
	endproperty
	a_mode: assert property (p_mode) else $error("mode word not stored");
	property p_cnt;
		wr_cmd && code == C_BURST_CNT && pwdata[9] |=> axis_params[1].burst_count == wl_reg;
	endproperty
	a_cnt: assert property (p_cnt) else $error("burst count not stored");
	property p_unk;
		wr_cmd && code == 8'h70 |=> $stable(axis_params);
	endproperty
	a_unk: assert property (p_unk) else $error("unknown code changed parameters");
	property p_pulse;
		wr_cmd |=> cmd_out.valid && cmd_out.code == $past(code) ##1 !cmd_out.valid;
	endproperty
	a_pulse: assert property (p_pulse) else $error("command strobe wrong");
	property p_rdro;
		psel && penable && pwrite && (paddr == OFS_RDATA_LOW || paddr == OFS_RDATA_HIGH) |-> pslverr;
	endproperty
	a_rdro: assert property (p_rdro) else $error("read data register took a write");
	property p_rdfast;
		psel && penable && !pwrite |-> pready;
	endproperty
	a_rdfast: assert property (p_rdfast) else $error("read stalled");
endmodule

bind mpcd_decoder mpcd_decoder_props mpcd_decoder_props_i (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .axis_params, .cmd_out);

// ==== tb/mpcd_host.sv ====
/*
 Host model: APB master that loads data words and issues commands.
 Assumes the decoder answers on pready and flags refusals on pslverr.
*/
`timescale 1ns/1ps
module mpcd_host
	import mpcd_pkg::*;
(
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// idle bus at time zero
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
	end

	// one transfer; released address and data show the inverse, not a stale value; pwrite keeps its value
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~a;
		pwdata  <= ~d;
	endtask

	// full data length first, high then low, command last
	task automatic cmd(input logic [1:0] ax, input logic [7:0] c, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, OFS_WDATA_HIGH, {16'h0000, d[31:16]}, q, e);
		xfer(1'b1, OFS_WDATA_LOW, {16'h0000, d[15:0]}, q, e);
		xfer(1'b1, OFS_COMMAND, {22'h000000, ax, c}, q, e);
	endtask
endmodule

// ==== tb/mpcd_decoder_bench.sv ====
/*
 Testbench: parameter, mode and read commands through the host model.
 Assumes 100 MHz pclk; values are in 16 MHz units, as the host sends them.
*/
`timescale 1ns/1ps
`define CHK(n, x, g) begin tests_run++; if ((g) !== (x)) begin n_mismatch++; $display("Error %s exp %h got %h", n, x, g); end end
module mpcd_decoder_bench;
	import mpcd_pkg::*;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, q;
	mpcd_live_s [1:0]   live;
	mpcd_params_s [1:0] prm;
	mpcd_cmd_s          cmd_o;
	int                 tests_run, n_mismatch;
	logic [7:0]         wo [10] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h08, 8'h0b, 8'h0c, 8'h14, 8'h15, 8'h16};
	logic [31:0]        wov [10] = '{MAX_JERK, 32'h1, 32'h1, MAX_SLOW, 32'h8000_0002, 32'h8000_0001,
		MAX_TIME, MAX_SPEED, MAX_STEP, MAX_TIME};
	logic [7:0]         rw [12] = '{8'h02, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0a, 8'h10, 8'h11, 8'h12, 8'h13,
		8'h17, 8'h19};
	logic [7:0]         rr [12] = '{8'h43, 8'h44, 8'h45, 8'h46, 8'h30, 8'h31, 8'h34, 8'h35, 8'h36, 8'h37,
		8'h47, 8'h39};
	logic [31:0]        rv [12] = '{MAX_RATE, MAX_SPEED, 32'h1, 32'h8000_0002, MOST_NEG, MAX_TIME, MOST_NEG,
		32'hffff_ffff, 32'h1234_5678, 32'h1, 32'hfffe_0002, MAX_POS};

	mpcd_decoder mpcd_decoder_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .axis_live(live), .axis_params(prm), .cmd_out(cmd_o));
	mpcd_host mpcd_host_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

	// free-running clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// write-only field picked by code
	function automatic logic [31:0] fld(input mpcd_params_s p, input logic [7:0] c);
		case (c)
			8'h00: return p.ramp_up_jerk;
			8'h01: return p.ramp_down_jerk;
			8'h03: return p.speed_ramp_down_rate;
			8'h07: return p.manual_slowdown_point;
			8'h08: return p.arc_center;
			8'h0b: return p.upper_soft_bound;
			8'h0c: return p.lower_soft_bound;
			8'h14: return p.homing_speed;
			8'h15: return p.speed_step;
			default: return p.timer_preset;
		endcase
	endfunction

	// issue a read command, then fetch both read words
	task automatic rdres(input logic [1:0] ax, input logic [7:0] c, input logic [31:0] x);
		mpcd_host_i.cmd(ax, c, 32'h0000_0000);
		mpcd_host_i.xfer(1'b0, OFS_RDATA_LOW, 32'h0, q, e);
		`CHK("read low", {16'h0000, x[15:0]}, q)
		mpcd_host_i.xfer(1'b0, OFS_RDATA_HIGH, 32'h0, q, e);
		`CHK("read high", {16'h0000, x[31:16]}, q)
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// hang guard
	initial begin
		#300us;
		n_mismatch++;
		wrap_up();
	end

	// main sequence
	initial begin
		tests_run  = 0;
		n_mismatch = 0;
		presetn    = 1'b0;
		live       = '0;
		live[0].present_speed       = MAX_SPEED;
		live[0].present_ramp_rate   = MAX_RATE;
		live[0].present_timer       = MAX_TIME;
		live[0].general_input_value = 16'ha5c3;
		live[0].write_cfg1          = 16'h1111;
		live[0].write_cfg2          = 16'h2222;
		live[0].write_cfg3          = 16'h3333;
		live[1].present_speed       = 32'h0000_0007;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			mpcd_host_i.cmd(2'b11, wo[i], wov[i]);
			@(negedge pclk);
			`CHK("axis x field", wov[i], fld(prm[0], wo[i]))
			`CHK("axis y field", wov[i], fld(prm[1], wo[i]))
		end
		for (int i = 0; i < 12; i++) begin
			mpcd_host_i.cmd(2'b10, rw[i], rv[i]);
			rdres(2'b10, rr[i], rv[i]);
		end
		rdres(2'b01, 8'h44, 32'h0000_0000);
		for (int k = 0; k < 12; k++)
			mpcd_host_i.cmd(2'b01, 8'h20 + 8'(k), {16'hbeef, 16'h0a00 + 16'(k)});
		rdres(2'b01, 8'h40, 32'h0000_0a00);
		rdres(2'b01, 8'h41, 32'h0000_0a01);
		rdres(2'b01, 8'h42, 32'h0000_0a02);
		rdres(2'b01, 8'h49, 32'h0000_0a0b);
		mpcd_host_i.cmd(2'b10, 8'h18, 32'h1234_ffff);
		@(negedge pclk);
		`CHK("burst count", 16'hffff, prm[1].burst_count)
		rdres(2'b01, 8'h3d, 32'h0000_1111);
		rdres(2'b01, 8'h3e, 32'h0000_2222);
		rdres(2'b01, 8'h3f, 32'h0000_3333);
		rdres(2'b01, 8'h33, MAX_RATE);
		rdres(2'b01, 8'h38, MAX_TIME);
		rdres(2'b10, 8'h32, 32'h0000_0007);
		rdres(2'b11, 8'h32, MAX_SPEED);
		rdres(2'b01, 8'h48, 32'h0000_a5c3);
		rdres(2'b01, 8'h70, 32'h0000_a5c3);
		mpcd_host_i.xfer(1'b1, OFS_RDATA_LOW, 32'h0000_5555, q, e);
		`CHK("ro write refused", 1'b1, e)
		mpcd_host_i.xfer(1'b0, 8'h18, 32'h0, q, e);
		`CHK("unmapped refused", 1'b1, e)
		`CHK("unmapped data", 32'h0000_0000, q)
		mpcd_host_i.xfer(1'b0, OFS_STATUS, 32'h0, q, e);
		`CHK("range flag idle", 32'h0000_0000, q)
		mpcd_host_i.cmd(2'b01, 8'h05, 32'h0000_0000);
		mpcd_host_i.xfer(1'b0, OFS_STATUS, 32'h0, q, e);
		`CHK("range and busy flags", 32'h0000_0003, q)
		mpcd_host_i.xfer(1'b0, OFS_COMMAND, 32'h0, q, e);
		`CHK("command readback", 32'h0000_0105, q)
		mpcd_host_i.xfer(1'b1, OFS_STATUS, 32'h0000_0001, q, e);
		mpcd_host_i.xfer(1'b0, OFS_STATUS, 32'h0, q, e);
		`CHK("range flag cleared", 32'h0000_0000, q)
		wrap_up();
	end
endmodule
